//--- verilog/spi_tx_pkg.sv
// constants and types shared by the transmit buffering logic
package spi_tx_pkg;
   localparam int WORD_WIDTH = 8;
   localparam int STATUS_WIDTH = 8;
   localparam int EMPTY_FLAG_BIT = 5;
   localparam int BUF_DEPTH = 2;
   localparam logic EMPTY_FLAG_RESET = 1'b1;
   localparam logic [7:0] WORD_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] BIT_CNT_RESET = 3'h0;
   localparam logic [1:0] FILL_RESET = 2'h0;
   localparam logic [1:0] FILL_FULL = 2'h2;

   typedef enum logic [0:0] {
      XF_IDLE = 1'b0,
      XF_WAIT = 1'b1
   } xfer_state_t;
endpackage

//--- verilog/spi_stream_if.sv
// valid/ready word stream between the transmit buffering modules
`timescale 1ns/100ps
`default_nettype none
interface spi_stream_if;
   logic valid;
   logic ready;
   logic [spi_tx_pkg::WORD_WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- verilog/spi_tx_skid.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module spi_tx_skid (
   input wire logic core_clk,
   input wire logic sys_rst,
   spi_stream_if.snk in_s,
   spi_stream_if.src out_s
);
   logic [spi_tx_pkg::WORD_WIDTH-1:0] mem_r [spi_tx_pkg::BUF_DEPTH];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] fill_r;
   logic push;
   logic pop;

   assign in_s.ready = (fill_r != spi_tx_pkg::FILL_FULL);
   assign out_s.valid = (fill_r != spi_tx_pkg::FILL_RESET);
   assign out_s.data = mem_r[rd_ptr_r];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_s.data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         fill_r <= spi_tx_pkg::FILL_RESET;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push && !pop) begin
            fill_r <= fill_r + 2'h1;
         end else if (pop && !push) begin
            fill_r <= fill_r - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- verilog/spi_tx_buffer.sv
// transmit data buffer, empty flag and link-side shifter
// ---------------------------------------------------------------
// Overview of operation
// RL1: empty flag shown at status bit five
// RL2: flag high when buffer holds no word
// RL3: status read with flag set, then write
// RL4: unarmed data writes are dropped entirely
// RL5: idle path takes word quickly, flag resets
// RL6: finished shift loads queued word automatically
// RL7: nothing queued: flag stays, last word shifts out again
// RL8: continued transfer resends the last word
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module spi_tx_buffer (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic status_rd,
   input wire logic data_wr,
   input wire logic [7:0] data_wr_data,
   output logic [7:0] status_rdata_r,
   output logic tx_buffer_empty_flag_r,
   input wire logic link_clk,
   input wire logic link_sel_n,
   output logic serial_out_r
);
   // ---------------------------------------------------------------
   // software handshake and data buffer (core_clk)
   // ---------------------------------------------------------------
   logic armed_r;
   logic [7:0] data_buf_r;
   logic wr_accept;
   logic buf_to_path;

   spi_stream_if path_in ();
   spi_stream_if path_out ();

   assign wr_accept = data_wr && armed_r && tx_buffer_empty_flag_r;
   assign buf_to_path = path_in.valid && path_in.ready;
   assign path_in.valid = !tx_buffer_empty_flag_r;
   assign path_in.data = data_buf_r;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         armed_r <= 1'b0;
      end else if (data_wr) begin
         armed_r <= 1'b0; // RL4
      end else if (status_rd && tx_buffer_empty_flag_r) begin
         armed_r <= 1'b1; // RL3
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         data_buf_r <= spi_tx_pkg::WORD_RESET;
      end else if (wr_accept) begin
         data_buf_r <= data_wr_data; // RL3
      end
   end

   // the word leaving the buffer empties it; a write is only
   // accepted while empty, so the two never meet
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_buffer_empty_flag_r <= spi_tx_pkg::EMPTY_FLAG_RESET;
      end else if (wr_accept) begin
         tx_buffer_empty_flag_r <= 1'b0; // RL2
      end else if (buf_to_path) begin
         tx_buffer_empty_flag_r <= 1'b1; // RL5
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_rdata_r <= spi_tx_pkg::STATUS_RESET;
      end else if (status_rd) begin
         status_rdata_r <= spi_tx_pkg::STATUS_RESET;
         status_rdata_r[spi_tx_pkg::EMPTY_FLAG_BIT] <=
            tx_buffer_empty_flag_r; // RL1
      end
   end

   spi_tx_skid u_skid (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_s(path_in),
      .out_s(path_out)
   );

   // ---------------------------------------------------------------
   // word handover to the link domain (toggle handshake)
   // ---------------------------------------------------------------
   spi_tx_pkg::xfer_state_t xf_state_r;
   logic offer_tgl_r;
   logic [7:0] offer_word_r;
   logic ack_q1_r;
   logic ack_q2_r;
   logic ack_tgl_r;

   // the buffer only drains when the link has taken the last word,
   // so a stalled shifter backs up into the buffer and flag
   assign path_out.ready = (xf_state_r == spi_tx_pkg::XF_IDLE);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack_q1_r <= 1'b0;
         ack_q2_r <= 1'b0;
      end else begin
         ack_q1_r <= ack_tgl_r;
         ack_q2_r <= ack_q1_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         xf_state_r <= spi_tx_pkg::XF_IDLE;
         offer_tgl_r <= 1'b0;
         offer_word_r <= spi_tx_pkg::WORD_RESET;
      end else begin
         unique case (xf_state_r)
            spi_tx_pkg::XF_IDLE: begin
               if (path_out.valid) begin
                  offer_word_r <= path_out.data;
                  offer_tgl_r <= ~offer_tgl_r;
                  xf_state_r <= spi_tx_pkg::XF_WAIT;
               end
            end
            spi_tx_pkg::XF_WAIT: begin
               if (ack_q2_r == offer_tgl_r) begin
                  xf_state_r <= spi_tx_pkg::XF_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // link side shifter (link_clk)
   // ---------------------------------------------------------------
   logic rst_q1_r;
   logic link_rst_r;
   logic sel_q1_r;
   logic sel_n_r;
   logic offer_q1_r;
   logic offer_q2_r;
   logic has_next_r;
   logic [7:0] next_word_r;
   logic [7:0] shift_r;
   logic [7:0] last_word_r;
   logic [2:0] bit_cnt_r;
   logic take_offer;
   logic load_now;

   assign take_offer = (offer_q2_r != ack_tgl_r) && !has_next_r;
   assign load_now = !sel_n_r && (bit_cnt_r == spi_tx_pkg::BIT_CNT_RESET);

   always_ff @(posedge link_clk) begin
      rst_q1_r <= sys_rst;
      link_rst_r <= rst_q1_r;
   end

   always_ff @(posedge link_clk) begin
      if (link_rst_r) begin
         sel_q1_r <= 1'b1;
         sel_n_r <= 1'b1;
         offer_q1_r <= 1'b0;
         offer_q2_r <= 1'b0;
      end else begin
         sel_q1_r <= link_sel_n;
         sel_n_r <= sel_q1_r;
         offer_q1_r <= offer_tgl_r;
         offer_q2_r <= offer_q1_r;
      end
   end

   // the offered word is stable until the ack returns, so it may be
   // sampled here directly once the toggle has been synchronised
   always_ff @(posedge link_clk) begin
      if (link_rst_r) begin
         has_next_r <= 1'b0;
         next_word_r <= spi_tx_pkg::WORD_RESET;
         ack_tgl_r <= 1'b0;
      end else begin
         if (take_offer) begin
            next_word_r <= offer_word_r;
            ack_tgl_r <= ~ack_tgl_r;
         end
         if (take_offer) begin
            has_next_r <= 1'b1;
         end else if (load_now && has_next_r) begin
            has_next_r <= 1'b0; // RL6
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_rst_r) begin
         bit_cnt_r <= spi_tx_pkg::BIT_CNT_RESET;
         shift_r <= spi_tx_pkg::WORD_RESET;
         last_word_r <= spi_tx_pkg::WORD_RESET;
         serial_out_r <= 1'b0;
      end else if (sel_n_r) begin
         bit_cnt_r <= spi_tx_pkg::BIT_CNT_RESET;
      end else if (load_now) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (has_next_r) begin
            shift_r <= {next_word_r[6:0], 1'b0}; // RL6
            last_word_r <= next_word_r;
            serial_out_r <= next_word_r[7];
         end else begin
            shift_r <= {last_word_r[6:0], 1'b0}; // RL8
            serial_out_r <= last_word_r[7]; // RL7
         end
      end else begin
         bit_cnt_r <= (bit_cnt_r == spi_tx_pkg::LAST_BIT) ?
            spi_tx_pkg::BIT_CNT_RESET : bit_cnt_r + 3'h1;
         shift_r <= {shift_r[6:0], 1'b0};
         serial_out_r <= shift_r[7];
      end
   end
endmodule
`default_nettype wire

//--- testbench/spi_tx_buffer_properties.sv
// assertions on the transmit buffer ports
`timescale 1ns/100ps
`default_nettype none
module spi_tx_buffer_properties (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic status_rd,
   input wire logic data_wr,
   input wire logic [7:0] data_wr_data,
   input wire logic [7:0] status_rdata_r,
   input wire logic tx_buffer_empty_flag_r,
   input wire logic link_clk,
   input wire logic link_sel_n,
   input wire logic serial_out_r
);
   logic armed_r;
   wire acc = data_wr & armed_r;
   wire fl = tx_buffer_empty_flag_r;
   // any write disarms, so only one write follows each read
   always_ff @(posedge core_clk) begin
      if (sys_rst || data_wr)
         armed_r <= 1'b0;
      else if (status_rd && fl)
         armed_r <= 1'b1;
   end
   AST_STAT_VAL: assert property (@(posedge core_clk)
      disable iff (sys_rst) status_rd |=> status_rdata_r ==
      {2'h0, $past(fl), 5'h00}) else $error("status value wrong");
   AST_STAT_HOLD: assert property (@(posedge core_clk)
      disable iff (sys_rst) !status_rd |=> $stable(status_rdata_r))
      else $error("status changed without read");
   AST_STAT_BITS: assert property (@(posedge core_clk)
      disable iff (sys_rst) (status_rdata_r & 8'hDF) == 8'h00)
      else $error("status spare bits set");
   AST_FLAG_FALL: assert property (@(posedge core_clk)
      disable iff (sys_rst) acc |=> !fl) else $error("flag kept");
   AST_FALL_CAUSE: assert property (@(posedge core_clk)
      disable iff (sys_rst) $fell(fl) |-> $past(acc))
      else $error("flag fell without write");
   AST_FLAG_STAY: assert property (@(posedge core_clk)
      disable iff (sys_rst) fl && !acc |=> fl) else $error("flag lost");
   AST_UNARMED: assert property (@(posedge core_clk)
      disable iff (sys_rst) data_wr && !armed_r && fl |=> fl)
      else $error("unarmed write taken");
   AST_LINK_ONLY: assert property (@(posedge link_clk)
      disable iff (sys_rst) $changed(serial_out_r) |->
      !$past(link_sel_n, 3)) else $error("output moved off frame");
   cover property (@(posedge core_clk) acc);
   cover property (@(posedge core_clk) data_wr && !armed_r);
   cover property (@(posedge core_clk) $rose(fl));
endmodule
`default_nettype wire

//--- testbench/link_master_model.sv
// link master model: frames words and collects the shifted bits
`timescale 1ns/100ps
`default_nettype none
module link_master_model (
   output logic link_clk,
   output logic link_sel_n,
   input wire logic serial_out_r
);
   logic [7:0] got_q[$];
   logic [7:0] sr;
   initial begin
      link_clk = 1'b0;
      link_sel_n = 1'b1;
   end
   // clock runs only around frames and the reset sequence, so idle shows no edges
   task automatic pulses(input int n);
      repeat (n) begin
         #7.5 link_clk = 1'b1;
         #7.5 link_clk = 1'b0;
      end
   endtask
   // three deselected edges let the word handover cross first, two
   // more feed the select synchroniser; select rises two edges early
   // so the synchroniser is idle again when the last bit is out
   task automatic frame(input int nw);
      pulses(3);
      #3.3 link_sel_n = 1'b0;
      pulses(2);
      for (int i = 0; i < nw * 8; i++) begin
         pulses(1);
         sr = {sr[6:0], serial_out_r};
         if (i % 8 == 7)
            got_q.push_back(sr);
         if (i == nw * 8 - 3)
            link_sel_n = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the transmit buffer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
n_errors++; $display("BAD %0t value mismatch", $time); end end
module testbench;
   logic core_clk, sys_rst, status_rd, data_wr;
   logic [7:0] data_wr_data;
   wire [7:0] status_rdata_r;
   wire tx_buffer_empty_flag_r, link_clk, link_sel_n, serial_out_r;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   spi_tx_buffer DUT (.core_clk(core_clk), .sys_rst(sys_rst),
      .status_rd(status_rd), .data_wr(data_wr),
      .data_wr_data(data_wr_data), .status_rdata_r(status_rdata_r),
      .tx_buffer_empty_flag_r(tx_buffer_empty_flag_r),
      .link_clk(link_clk), .link_sel_n(link_sel_n),
      .serial_out_r(serial_out_r));
   link_master_model lm (.link_clk(link_clk), .link_sel_n(link_sel_n),
      .serial_out_r(serial_out_r));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         $display("BAD %0t hung", $time);
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // optional status read, then a data write one cycle later
   task automatic put(input logic [7:0] d, input logic rd);
      @(posedge core_clk);
      status_rd <= rd;
      @(posedge core_clk);
      status_rd <= 1'b0;
      data_wr <= 1'b1;
      data_wr_data <= d;
      @(posedge core_clk);
      data_wr <= 1'b0;
      #1;
   endtask
   task automatic t_single();
      put(8'hA5, 1'b0);
      `CHK(tx_buffer_empty_flag_r, 1'b1)
      put(8'h3C, 1'b1);
      `CHK(status_rdata_r, 8'h20)
      `CHK(tx_buffer_empty_flag_r, 1'b0)
      tick(1);
      `CHK(tx_buffer_empty_flag_r, 1'b1)
      put(8'h77, 1'b0);
      tick(10);
      lm.frame(1);
      tick(10);
      `CHK(lm.got_q.pop_front(), 8'h3C)
   endtask
   // fill the queue until the flag stays low, then drain word by word;
   // with the link stopped four words fit, the last two are refused
   task automatic t_fill();
      for (int i = 0; i < 6; i++) begin
         put(8'h10 + 8'(i), 1'b1);
         tick(3);
      end
      `CHK(status_rdata_r, 8'h00)
      `CHK(tx_buffer_empty_flag_r, 1'b0)
      for (int i = 0; i < 4; i++) begin
         lm.frame(1);
         tick(10);
         `CHK(lm.got_q.pop_front(), 8'h10 + 8'(i))
      end
      `CHK(tx_buffer_empty_flag_r, 1'b1)
      lm.frame(1);
      `CHK(lm.got_q.pop_front(), 8'h13)
   endtask
   initial begin
      sys_rst = 1'b1;
      status_rd = 1'b0;
      data_wr = 1'b0;
      data_wr_data = 8'h00;
      lm.pulses(4);
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      tick(1);
      // the link side leaves reset only on link edges
      lm.pulses(3);
      `CHK(tx_buffer_empty_flag_r, 1'b1)
      `CHK(status_rdata_r, 8'h00)
      t_single();
      t_fill();
      report_and_stop();
   end
endmodule
bind spi_tx_buffer spi_tx_buffer_properties chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .status_rd(status_rd), .data_wr(data_wr),
   .data_wr_data(data_wr_data), .status_rdata_r(status_rdata_r),
   .tx_buffer_empty_flag_r(tx_buffer_empty_flag_r),
   .link_clk(link_clk), .link_sel_n(link_sel_n),
   .serial_out_r(serial_out_r));
`default_nettype wire
